// File: hw/ccsc_pkg.sv
// package with octet field layouts and code values for cause and circuit state coding
package ccsc_pkg;
   // cause octet layout
   localparam int CAUSE_VALUE_W = 7;
   localparam int CLASS_LSB = 4;
   localparam int CLASS_W = 3;
   localparam int VALUE_IN_CLASS_W = 4;
   localparam int EXT_BIT = 7;
   // cause classes
   localparam logic [2:0] CLASS_NORMAL0 = 3'h0;
   localparam logic [2:0] CLASS_NORMAL1 = 3'h1;
   localparam logic [2:0] CLASS_RESOURCE = 3'h2;
   localparam logic [2:0] CLASS_NOT_AVAIL = 3'h3;
   localparam logic [2:0] CLASS_NOT_IMPL = 3'h4;
   localparam logic [2:0] CLASS_INVALID = 3'h5;
   localparam logic [2:0] CLASS_PROTOCOL = 3'h6;
   localparam logic [2:0] CLASS_INTERWORK = 3'h7;
   // named cause values
   localparam logic [6:0] CAUSE_UNALLOCATED = 7'h01;
   localparam logic [6:0] CAUSE_NO_ROUTE_TRANSIT = 7'h02;
   localparam logic [6:0] CAUSE_NO_ROUTE_DEST = 7'h03;
   localparam logic [6:0] CAUSE_NORMAL_CLEARING = 7'h10;
   localparam logic [6:0] CAUSE_USER_BUSY = 7'h11;
   localparam logic [6:0] CAUSE_CALL_REJECTED = 7'h15;
   localparam logic [6:0] CAUSE_NUMBER_CHANGED = 7'h16;
   localparam logic [6:0] CAUSE_FACILITY_REJECTED = 7'h1d;
   localparam logic [6:0] CAUSE_NORMAL_UNSPEC = 7'h1f;
   localparam logic [6:0] CAUSE_NO_CIRCUIT = 7'h22;
   localparam logic [6:0] CAUSE_CONGESTION = 7'h2a;
   localparam logic [6:0] CAUSE_RESOURCE_UNSPEC = 7'h2f;
   localparam logic [6:0] CAUSE_NOT_SUBSCRIBED = 7'h32;
   localparam logic [6:0] CAUSE_BEARER_NOT_AUTH = 7'h39;
   localparam logic [6:0] CAUSE_BEARER_NOT_PRESENT = 7'h3a;
   localparam logic [6:0] CAUSE_NOT_AVAIL_UNSPEC = 7'h3f;
   localparam logic [6:0] CAUSE_BEARER_NOT_IMPL = 7'h41;
   localparam logic [6:0] CAUSE_FACILITY_NOT_IMPL = 7'h45;
   localparam logic [6:0] CAUSE_NOT_IMPL_UNSPEC = 7'h4f;
   localparam logic [6:0] CAUSE_NOT_CUG_MEMBER = 7'h57;
   localparam logic [6:0] CAUSE_INCOMPATIBLE_DEST = 7'h58;
   localparam logic [6:0] CAUSE_INVALID_UNSPEC = 7'h5f;
   localparam logic [6:0] CAUSE_UNKNOWN_MSG = 7'h61;
   localparam logic [6:0] CAUSE_PARAM_DISCARDED = 7'h63;
   localparam logic [6:0] CAUSE_PARAM_PASSED = 7'h67;
   localparam logic [6:0] CAUSE_PROTOCOL_UNSPEC = 7'h6f;
   localparam logic [6:0] CAUSE_INTERWORK_UNSPEC = 7'h7f;
   // attribute number range
   localparam logic [6:0] ATTR_FIRST = 7'h31;
   localparam logic [6:0] ATTR_LAST = 7'h39;
   // condition and indicator codes
   localparam logic [1:0] COND_SPARE = 2'h3;
   localparam logic [1:0] SUPV_SPARE = 2'h3;
   localparam logic [1:0] CP_NONE = 2'h0;
   localparam logic [1:0] CP_IDLE = 2'h3;
   localparam logic [1:0] BLK_NONE = 2'h0;
   // diagnostic kind selected by cause value
   typedef enum logic [2:0] {
      CCSC_DIAG_NONE,
      CCSC_DIAG_CONDITION,
      CCSC_DIAG_ATTRIBUTE,
      CCSC_DIAG_MSG_TYPE,
      CCSC_DIAG_PARAM_NAMES,
      CCSC_DIAG_NAMED_PARAM
   } ccsc_diag_type;
endpackage

// File: hw/ccsc_link_if.sv
// interface carrying parameter octets between the two signalling ends
`timescale 1ns/1ps
`default_nettype none
interface ccsc_link_if;
   logic valid;
   logic [7:0] octet;
   logic last;
   logic [2:0] field;
   modport device (output valid, output octet, output last, output field);
   modport peer (input valid, input octet, input last, input field);
endinterface
`default_nettype wire

// File: hw/ccsc_encoder.sv
// encoder end: builds cause, diagnostic and circuit state octets
`timescale 1ns/1ps
`default_nettype none
module ccsc_encoder #(
   parameter int CIC_W = 12,
   parameter int RANGE_W = 8
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] kind_in,
   input wire logic start_in,
   input wire logic [6:0] cause_in,
   input wire logic [1:0] cond_in,
   input wire logic [6:0] attr_num_in,
   input wire logic [6:0] attr_rej_in,
   input wire logic [6:0] attr_mask_in,
   input wire logic attr_avail_en_in,
   input wire logic [6:0] attr_avail_in,
   input wire logic [7:0] diag_name_in,
   input wire logic [1:0] supv_type_in,
   input wire logic [RANGE_W-1:0] range_in,
   input wire logic [CIC_W-1:0] cic_base_in,
   input wire logic [1:0] maint_in,
   input wire logic [1:0] call_in,
   input wire logic [1:0] hw_in,
   output logic busy_out,
   output logic need_state_out,
   output logic [CIC_W-1:0] state_cic_out,
   output logic bad_in_out,
   ccsc_link_if.device link
);
   import ccsc_pkg::*;

   typedef enum logic [2:0] {
      CCSC_IDLE, CCSC_CAUSE, CCSC_DIAG0, CCSC_DIAG1, CCSC_DIAG2, CCSC_STATE
   } ccsc_enc_state_type;

   ccsc_enc_state_type st_r, st_nxt;
   logic valid_r, valid_nxt, last_r, last_nxt;
   logic [7:0] octet_r, octet_nxt;
   logic [2:0] field_r, field_nxt;
   logic [RANGE_W-1:0] cnt_r, cnt_nxt;
   ccsc_diag_type diag_r, diag_nxt, diag_sel;
   logic [1:0] call_fix;
   logic cause_ok;

   // diagnostic kind for a network cause
   always_comb
   begin
      case (cause_in)
         CAUSE_UNALLOCATED, CAUSE_NO_ROUTE_DEST, CAUSE_NORMAL_CLEARING,
         CAUSE_CALL_REJECTED: diag_sel = CCSC_DIAG_CONDITION;
         CAUSE_BEARER_NOT_AUTH, CAUSE_BEARER_NOT_PRESENT,
         CAUSE_BEARER_NOT_IMPL: diag_sel = CCSC_DIAG_ATTRIBUTE;
         CAUSE_UNKNOWN_MSG: diag_sel = CCSC_DIAG_MSG_TYPE;
         CAUSE_PARAM_DISCARDED, CAUSE_PARAM_PASSED: diag_sel = CCSC_DIAG_PARAM_NAMES;
         CAUSE_NO_ROUTE_TRANSIT, CAUSE_NUMBER_CHANGED, CAUSE_FACILITY_REJECTED,
         CAUSE_NOT_SUBSCRIBED, CAUSE_FACILITY_NOT_IMPL:
            diag_sel = CCSC_DIAG_NAMED_PARAM;
         default: diag_sel = CCSC_DIAG_NONE;
      endcase
   end

   // interworking class allows only its single code
   assign cause_ok = (cause_in[6:4] != CLASS_INTERWORK) ||
                     (cause_in == CAUSE_INTERWORK_UNSPEC);
   // hardware blocking pins call state to idle; a caller slip is fixed, not sent
   assign call_fix = (hw_in != BLK_NONE) ? CP_IDLE : call_in;

   // sequencing of the octets of one parameter field
   always_comb
   begin
      st_nxt = st_r;
      valid_nxt = 1'b0;
      last_nxt = 1'b0;
      octet_nxt = octet_r;
      field_nxt = field_r;
      cnt_nxt = cnt_r;
      diag_nxt = diag_r;
      case (st_r)
         CCSC_IDLE:
         begin
            if (start_in)
            begin
               field_nxt = kind_in;
               diag_nxt = diag_sel;
               valid_nxt = 1'b1;
               case (kind_in)
                  3'h0:
                  begin
                     // cause octet: ext bit 7, class bits 6-4, value bits 3-0
                     octet_nxt = {(diag_sel == CCSC_DIAG_NONE),
                                  cause_in[CLASS_LSB +: CLASS_W],
                                  cause_in[0 +: VALUE_IN_CLASS_W]};
                     last_nxt = (diag_sel == CCSC_DIAG_NONE);
                     st_nxt = last_nxt ? CCSC_IDLE : CCSC_DIAG0;
                  end
                  3'h1:
                  begin
                     octet_nxt = {6'h00, supv_type_in};
                     last_nxt = 1'b1;
                  end
                  default:
                  begin
                     octet_nxt = (call_fix == CP_NONE) ? {6'h00, maint_in}
                        : {2'h0, hw_in, call_fix, maint_in};
                     cnt_nxt = range_in;
                     last_nxt = (range_in == '0);
                     st_nxt = last_nxt ? CCSC_IDLE : CCSC_STATE;
                  end
               endcase
            end
         end
         CCSC_DIAG0:
         begin
            valid_nxt = 1'b1;
            case (diag_r)
               CCSC_DIAG_CONDITION:
               begin
                  octet_nxt = {1'b1, 5'h00, cond_in};
                  last_nxt = 1'b1;
                  st_nxt = CCSC_IDLE;
               end
               CCSC_DIAG_ATTRIBUTE:
               begin
                  octet_nxt = {1'b0, attr_num_in};
                  st_nxt = CCSC_DIAG1;
               end
               default:
               begin
                  // named diagnostics open with name then length octet
                  octet_nxt = diag_name_in;
                  st_nxt = CCSC_DIAG1;
               end
            endcase
         end
         CCSC_DIAG1:
         begin
            valid_nxt = 1'b1;
            if (diag_r == CCSC_DIAG_ATTRIBUTE)
            begin
               octet_nxt = {!attr_avail_en_in, attr_rej_in & attr_mask_in};
               last_nxt = !attr_avail_en_in;
               st_nxt = attr_avail_en_in ? CCSC_DIAG2 : CCSC_IDLE;
            end
            else
            begin
               octet_nxt = 8'h00;
               last_nxt = 1'b1;
               st_nxt = CCSC_IDLE;
            end
         end
         CCSC_DIAG2:
         begin
            valid_nxt = 1'b1;
            octet_nxt = {1'b1, attr_avail_in & attr_mask_in};
            last_nxt = 1'b1;
            st_nxt = CCSC_IDLE;
         end
         CCSC_STATE:
         begin
            valid_nxt = 1'b1;
            octet_nxt = (call_fix == CP_NONE) ? {6'h00, maint_in}
               : {2'h0, hw_in, call_fix, maint_in};
            cnt_nxt = cnt_r - 1'b1;
            last_nxt = (cnt_r == 1);
            st_nxt = last_nxt ? CCSC_IDLE : CCSC_STATE;
         end
         default: st_nxt = CCSC_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_r <= CCSC_IDLE;
         valid_r <= 1'b0;
         last_r <= 1'b0;
         octet_r <= 8'h00;
         field_r <= 3'h0;
         cnt_r <= '0;
         diag_r <= CCSC_DIAG_NONE;
      end
      else
      begin
         st_r <= st_nxt;
         valid_r <= valid_nxt;
         last_r <= last_nxt;
         octet_r <= octet_nxt;
         field_r <= field_nxt;
         cnt_r <= cnt_nxt;
         diag_r <= diag_nxt;
      end
   end

   // state octet index n is range-cnt+1 counting from the first octet
   assign state_cic_out = cic_base_in + CIC_W'(range_in - cnt_nxt);
   assign need_state_out = (st_r == CCSC_STATE) ||
                           (st_r == CCSC_IDLE && start_in && kind_in >= 3'h2);
   assign busy_out = (st_r != CCSC_IDLE);
   assign bad_in_out = start_in && kind_in == 3'h0 && !cause_ok;
   assign link.valid = valid_r;
   assign link.octet = octet_r;
   assign link.last = last_r;
   assign link.field = field_r;
endmodule // ccsc_encoder
`default_nettype wire

// File: hw/ccsc_decoder.sv
// decoder end: interprets received parameter octets and flags undefined codes
`timescale 1ns/1ps
`default_nettype none
module ccsc_decoder (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   ccsc_link_if.peer link,
   output logic [6:0] cause_out,
   output logic [2:0] cause_class_out,
   output logic cause_valid_out,
   output logic diag_valid_out,
   output logic [7:0] diag_octet_out,
   output logic [1:0] supv_type_out,
   output logic supv_valid_out,
   output logic [1:0] maint_out,
   output logic [1:0] call_out,
   output logic [1:0] hw_out,
   output logic state_valid_out,
   output logic spare_code_out,
   output logic hw_rule_err_out
);
   import ccsc_pkg::*;

   logic in_diag_r, in_diag_nxt;
   logic [7:0] do_r, do_nxt;
   logic [6:0] cause_r, cause_nxt;
   logic [1:0] supv_r, supv_nxt, maint_r, maint_nxt, call_r, call_nxt, hw_r, hw_nxt;
   logic cv_r, cv_nxt, dv_r, dv_nxt, sv_r, sv_nxt, stv_r, stv_nxt, sp_r, sp_nxt;
   logic herr_r, herr_nxt;
   logic cause_known;

   // defined cause values; anything else is reported as spare
   always_comb
   begin
      case (link.octet[6:0])
         7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h10, 7'h11, 7'h12, 7'h13, 7'h15, 7'h16,
         7'h1b, 7'h1c, 7'h1d, 7'h1f, 7'h22, 7'h26, 7'h29, 7'h2a, 7'h2c, 7'h2f,
         7'h32, 7'h37, 7'h39, 7'h3a, 7'h3f, 7'h41, 7'h45, 7'h46, 7'h4f,
         7'h57, 7'h58, 7'h5b, 7'h5f, 7'h61, 7'h63, 7'h67, 7'h6f, 7'h7f:
            cause_known = 1'b1;
         default: cause_known = 1'b0;
      endcase
   end

   // interpret each octet by field kind; the first cause octet opens a diagnostic unless it is marked last
   always_comb
   begin
      in_diag_nxt = in_diag_r;
      do_nxt = do_r;
      cause_nxt = cause_r;
      supv_nxt = supv_r;
      maint_nxt = maint_r;
      call_nxt = call_r;
      hw_nxt = hw_r;
      cv_nxt = 1'b0;
      dv_nxt = 1'b0;
      sv_nxt = 1'b0;
      stv_nxt = 1'b0;
      sp_nxt = 1'b0;
      herr_nxt = 1'b0;
      if (link.valid)
      begin
         case (link.field)
            3'h0:
            begin
               if (!in_diag_r)
               begin
                  cause_nxt = link.octet[6:0];
                  cv_nxt = 1'b1;
                  sp_nxt = !cause_known;
               end
               else
               begin
                  // absent optional octets simply end with last set
                  do_nxt = link.octet;
                  dv_nxt = 1'b1;
               end
               in_diag_nxt = !link.last;
            end
            3'h1:
            begin
               supv_nxt = link.octet[1:0];
               sv_nxt = 1'b1;
               sp_nxt = (link.octet[1:0] == SUPV_SPARE);
            end
            default:
            begin
               maint_nxt = link.octet[1:0];
               call_nxt = link.octet[3:2];
               hw_nxt = link.octet[5:4];
               stv_nxt = 1'b1;
               // DC zero with BA 01 or 10 is spare
               sp_nxt = (link.octet[3:2] == CP_NONE) && (^link.octet[1:0]);
               herr_nxt = (link.octet[5:4] != BLK_NONE) &&
                          (link.octet[3:2] != CP_IDLE);
            end
         endcase
      end
   end

   // registers
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         in_diag_r <= 1'b0;
         do_r <= 8'h00;
         cause_r <= 7'h00;
         supv_r <= 2'h0;
         maint_r <= 2'h0;
         call_r <= 2'h0;
         hw_r <= 2'h0;
         cv_r <= 1'b0;
         dv_r <= 1'b0;
         sv_r <= 1'b0;
         stv_r <= 1'b0;
         sp_r <= 1'b0;
         herr_r <= 1'b0;
      end
      else
      begin
         in_diag_r <= in_diag_nxt;
         do_r <= do_nxt;
         cause_r <= cause_nxt;
         supv_r <= supv_nxt;
         maint_r <= maint_nxt;
         call_r <= call_nxt;
         hw_r <= hw_nxt;
         cv_r <= cv_nxt;
         dv_r <= dv_nxt;
         sv_r <= sv_nxt;
         stv_r <= stv_nxt;
         sp_r <= sp_nxt;
         herr_r <= herr_nxt;
      end
   end

   assign cause_out = cause_r;
   assign cause_class_out = cause_r[CLASS_LSB +: CLASS_W];
   assign cause_valid_out = cv_r;
   assign diag_valid_out = dv_r;
   assign diag_octet_out = do_r;
   assign supv_type_out = supv_r;
   assign supv_valid_out = sv_r;
   assign maint_out = maint_r;
   assign call_out = call_r;
   assign hw_out = hw_r;
   assign state_valid_out = stv_r;
   assign spare_code_out = sp_r;
   assign hw_rule_err_out = herr_r;
endmodule // ccsc_decoder
`default_nettype wire

// File: verification/ccsc_link_sva.sv
// assertion checker watching the octet link between encoder and decoder
`timescale 1ns/1ps
`default_nettype none
module ccsc_link_sva (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic valid,
   input wire logic [7:0] octet,
   input wire logic last,
   input wire logic [2:0] field
);
   logic first_r;
   logic first_nxt;
   logic cause_hd;
   // an octet after a final one opens a new field
   always_comb
   begin
      first_nxt = first_r;
      if (valid)
         first_nxt = last;
   end
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         first_r <= 1'b1;
      else
         first_r <= first_nxt;
   end
   assign cause_hd = valid && first_r && (field == 3'h0);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // attribute number octet: another octet follows, code in the defined span
   sequence attr_num_s;
      valid && !last && !octet[7] && octet[6:0] >= 7'h31 && octet[6:0] <= 7'h39;
   endsequence
   sequence cond_octet_s;
      valid && last && octet[7:2] == 6'h20;
   endsequence
   AST_BACK_TO_BACK: assert property (valid && !last |=> valid && field == $past(field))
      else $error("field octets not back to back");
   AST_NO_DIAG_END: assert property (cause_hd && octet[7] |-> last)
      else $error("cause without diagnostic not final");
   AST_CONDITION: assert property (cause_hd && octet[6:0] inside {7'h01, 7'h03, 7'h10, 7'h15}
      |-> !octet[7] ##1 cond_octet_s)
      else $error("condition diagnostic malformed");
   AST_ATTRIBUTE: assert property (cause_hd && octet[6:0] inside {7'h39, 7'h3a, 7'h41}
      |-> !octet[7] ##1 attr_num_s ##1 valid)
      else $error("attribute diagnostic malformed");
   AST_NAMED_LEN: assert property (cause_hd && octet[6:0] == 7'h61
      |=> valid && !last ##1 valid && last && octet == 8'h00)
      else $error("named diagnostic without length octet");
   AST_SUPV_SPARE: assert property (valid && field == 3'h1 |-> last && octet[7:2] == 6'h00)
      else $error("supervision octet spare bits set");
   AST_HW_IDLE: assert property (valid && field >= 3'h2 && octet[5:4] != 2'h0
      |-> octet[3:2] == 2'h3)
      else $error("hardware blocked circuit not idle");
   AST_DC_ZERO: assert property (valid && field >= 3'h2 && octet[3:2] == 2'h0
      |-> octet[7:4] == 4'h0)
      else $error("spare bits set with call state zero");
   AST_GH_SPARE: assert property (valid && field >= 3'h2 |-> octet[7:6] == 2'h0)
      else $error("state octet spare bits set");
endmodule // ccsc_link_sva
`default_nettype wire

// File: verification/tb_cause_and_circuit_state_codec.sv
// self-checking bench: encoder and decoder joined back to back
`timescale 1ns/1ps
`default_nettype none
module tb_cause_and_circuit_state_codec;
   import ccsc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [2:0] kind_in, cause_class_out;
   logic start_in, attr_avail_en_in, busy_out, need_state_out, bad_in_out;
   logic spare_code_out, hw_rule_err_out;
   logic cause_valid_out, diag_valid_out, supv_valid_out, state_valid_out;
   logic [7:0] diag_octet_out;
   int n_cv, n_dv, n_sv, n_stv;
   logic [6:0] cause_in, attr_num_in, attr_rej_in, attr_mask_in, attr_avail_in, cause_out;
   logic [1:0] cond_in, supv_type_in, maint_in, call_in, hw_in;
   logic [1:0] supv_type_out, maint_out, call_out, hw_out;
   logic [7:0] diag_name_in, range_in;
   logic [11:0] cic_base_in, state_cic_out;
   int err_total = 0;
   int checks = 0;
   int seed = 32'h35ec3b3d;
   int n_st, n_spare, exp_spare, n_hwerr, i;
   logic [7:0] exp_q[$];
   logic [7:0] got_q[$];
   logic [7:0] so;
   ccsc_link_if link_bus ();
   ccsc_encoder #(.CIC_W(12), .RANGE_W(8)) ccsc_encoder_inst (.ref_clk_in, .rstn_in, .kind_in,
      .start_in, .cause_in, .cond_in, .attr_num_in, .attr_rej_in, .attr_mask_in,
      .attr_avail_en_in, .attr_avail_in, .diag_name_in, .supv_type_in, .range_in, .cic_base_in,
      .maint_in, .call_in, .hw_in, .busy_out, .need_state_out, .state_cic_out, .bad_in_out,
      .link(link_bus));
   ccsc_decoder ccsc_decoder_inst (.ref_clk_in, .rstn_in, .link(link_bus), .cause_out,
      .cause_class_out, .cause_valid_out, .diag_valid_out, .diag_octet_out,
      .supv_type_out, .supv_valid_out, .maint_out, .call_out, .hw_out, .state_valid_out,
      .spare_code_out, .hw_rule_err_out);
   ccsc_link_sva ccsc_link_sva_inst (.ref_clk_in, .rstn_in, .valid(link_bus.valid),
      .octet(link_bus.octet), .last(link_bus.last), .field(link_bus.field));
   always #20 ref_clk_in = ~ref_clk_in;
   task automatic complete_run();
      if (err_total == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // listed cause codes; anything else must come out flagged as spare
   function automatic bit known(input logic [6:0] c);
      return c inside {1, 2, 3, 4, 5, 16, 17, 18, 19, 21, 22, 27, 28, 29, 31, 34, 38, 41, 42,
         44, 47, 50, 55, 57, 58, 63, 65, 69, 70, 79, 87, 88, 91, 95, 97, 99, 103, 111, 127};
   endfunction
   // diagnostic kind: 1 condition, 2 attribute, 3 name plus length, 0 none
   function automatic int dkind(input logic [6:0] c);
      if (c inside {1, 3, 16, 21})
         return 1;
      if (c inside {57, 58, 65})
         return 2;
      if (c inside {2, 22, 29, 50, 69, 97, 99, 103})
         return 3;
      return 0;
   endfunction
   // circuit states are redrawn at random every cycle so state octets can differ
   always @(posedge ref_clk_in)
   begin
      #1;
      maint_in = 2'($random(seed));
      call_in = 2'($random(seed));
      hw_in = 2'($random(seed));
   end
   // link monitor and state octet model; sampled before the edge's updates land
   always @(posedge ref_clk_in)
   begin
      if (link_bus.valid === 1'b1)
         got_q.push_back(link_bus.octet);
      if (spare_code_out === 1'b1)
         n_spare++;
      if (hw_rule_err_out === 1'b1)
         n_hwerr++;
      // one decoder pulse per received octet of each kind
      n_cv += (cause_valid_out === 1'b1);
      n_dv += (diag_valid_out === 1'b1);
      n_sv += (supv_valid_out === 1'b1);
      n_stv += (state_valid_out === 1'b1);
      if (need_state_out === 1'b1)
      begin
         so = {2'h0, hw_in, (hw_in != 2'h0) ? 2'h3 : call_in, maint_in};
         exp_q.push_back(so);
         exp_spare += (so[3:2] == 2'h0 && so[1:0] inside {2'h1, 2'h2});
         check("state_cic", 32'(state_cic_out), 32'(cic_base_in + 12'(n_st)));
         n_st++;
      end
   end
   task automatic run(input logic [2:0] k, input logic [6:0] c, input logic [7:0] rng);
      int d;
      int cyc;
      @(posedge ref_clk_in);
      #1;
      kind_in = k;
      cause_in = c;
      range_in = rng;
      cond_in = 2'($random(seed));
      attr_num_in = 7'h31 + 7'($unsigned($random(seed)) % 9);
      attr_rej_in = 7'($random(seed));
      attr_mask_in = 7'($random(seed));
      attr_avail_en_in = 1'($random(seed));
      attr_avail_in = 7'($random(seed));
      diag_name_in = 8'($random(seed));
      supv_type_in = c[1:0];
      cic_base_in = 12'($random(seed));
      exp_q = {};
      got_q = {};
      n_st = 0;
      n_spare = 0;
      n_hwerr = 0;
      exp_spare = 0;
      n_cv = 0;
      n_dv = 0;
      n_sv = 0;
      n_stv = 0;
      d = dkind(c);
      if (k == 3'h0)
      begin
         exp_q.push_back({d == 0, c});
         if (d == 1)
            exp_q.push_back({6'h20, cond_in});
         if (d == 2)
         begin
            exp_q.push_back({1'b0, attr_num_in});
            exp_q.push_back({~attr_avail_en_in, attr_rej_in & attr_mask_in});
            if (attr_avail_en_in)
               exp_q.push_back({1'b1, attr_avail_in & attr_mask_in});
         end
         if (d == 3)
         begin
            exp_q.push_back(diag_name_in);
            exp_q.push_back(8'h00);
         end
         exp_spare = !known(c);
      end
      if (k == 3'h1)
      begin
         exp_q.push_back({6'h00, c[1:0]});
         exp_spare = (c[1:0] == 2'h3);
      end
      start_in = 1'b1;
      #2;
      check("bad_in", bad_in_out, k == 0 && c[6:4] == 3'h7 && c != 7'h7f);
      @(posedge ref_clk_in);
      #1;
      start_in = 1'b0;
      if (k == 3'h0 && d != 0)
      begin
         kind_in = 3'h1; // a start while busy must not disturb the cause field
         start_in = 1'b1;
         @(posedge ref_clk_in);
         #1;
         start_in = 1'b0;
      end
      for (cyc = 0; cyc < 400 && busy_out !== 1'b0; cyc++)
         @(posedge ref_clk_in);
      if (cyc == 400)
      begin
         err_total++;
         complete_run();
      end
      repeat (3) @(posedge ref_clk_in);
      #1;
      check("octet_count", got_q.size(), exp_q.size());
      foreach (got_q[j])
         check("octet", got_q[j], (j < exp_q.size()) ? exp_q[j] : 8'hxx);
      check("spare_count", n_spare, exp_spare);
      check("hw_err_count", n_hwerr, 0);
      if (k == 3'h0)
      begin
         check("cause", cause_out, c);
         check("class", cause_class_out, c[6:4]);
         check("cause_valid_count", n_cv, 1);
         check("diag_valid_count", n_dv, exp_q.size() - 1);
         if (d != 0)
            check("diag_octet", diag_octet_out, exp_q[$]);
      end
      if (k == 3'h1)
      begin
         check("supv", supv_type_out, c[1:0]);
         check("supv_valid_count", n_sv, 1);
      end
      if (k == 3'h2)
      begin
         // octet count from the range itself, not from the encoder's strobe
         check("state_octets", exp_q.size(), rng + 1);
         check("state_valid_count", n_stv, rng + 1);
      end
      if (k == 3'h2 && exp_q.size() > 0)
         check("state", {hw_out, call_out, maint_out}, exp_q[$][5:0]);
   endtask
   initial
   begin
      {kind_in, start_in, cause_in, cond_in, attr_num_in, attr_rej_in} = '0;
      {attr_mask_in, attr_avail_en_in, attr_avail_in, diag_name_in, supv_type_in} = '0;
      {range_in, cic_base_in, maint_in, call_in, hw_in} = '0;
      repeat (6) @(posedge ref_clk_in);
      #1;
      rstn_in = 1'b1;
      // every cause code, listed and spare, with its diagnostic
      for (i = 0; i < 128; i++)
         run(3'h0, 7'(i), 8'h00);
      for (i = 0; i < 4; i++)
         run(3'h1, 7'(i), 8'h00);
      run(3'h2, 7'h00, 8'h00);
      run(3'h2, 7'h00, 8'hff);
      for (i = 0; i < 6; i++)
         run(3'h2, 7'h00, 8'($unsigned($random(seed)) % 40));
      complete_run();
   end
endmodule // tb_cause_and_circuit_state_codec
`default_nettype wire
